// File: core/rasr_pkg.sv
// package: register map, field layout and reset values of the range/alarm bank
package rasr_pkg;
	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [7:0]  RANGE_SEL_ADDR   = 8'h14;
	localparam logic [7:0]  ALARM_STAT_ADDR  = 8'h20;
	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int          REF_DIS_BIT      = 6;
	localparam int          RANGE_LSB        = 0;
	localparam int          RANGE_W          = 4;
	localparam int          ACT_SUP_LOW_BIT  = 15;
	localparam int          ACT_SUP_HIGH_BIT = 14;
	localparam int          ACT_IN_LOW_BIT   = 11;
	localparam int          ACT_IN_HIGH_BIT  = 10;
	localparam int          TRP_SUP_LOW_BIT  = 7;
	localparam int          TRP_SUP_HIGH_BIT = 6;
	localparam int          TRP_IN_LOW_BIT   = 5;
	localparam int          TRP_IN_HIGH_BIT  = 4;
	localparam int          SUMMARY_BIT      = 0;
	// ****************************************************************
	// reset values and valid range codes
	// ****************************************************************
	localparam logic [3:0]  RANGE_RST        = 4'h0;
	localparam logic        REF_DIS_RST      = 1'b0;
	localparam logic [3:0]  RANGE_BIP_MAX    = 4'h4;
	localparam logic [3:0]  RANGE_UNI_MIN    = 4'h8;
	localparam logic [3:0]  RANGE_UNI_MAX    = 4'hb;
	localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
endpackage : rasr_pkg

// File: core/rasr_flag_if.sv
// interface: alarm flag bundle between top and flag holder
interface rasr_flag_if;
	logic [3:0] active;
	logic [3:0] tripped;
	logic       summary;
	modport holder (output active, output tripped, output summary);
	modport reader (input active, input tripped, input summary);
endinterface : rasr_flag_if

// File: core/rasr_flag_hold.sv
// module: registers the alarm flags fed in from the detection logic
module rasr_flag_hold (
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset_n,
	input  wire logic [3:0] i_active,
	input  wire logic [3:0] i_tripped,
	rasr_flag_if.holder     flags
);
	logic [3:0] act_ff;
	logic [3:0] trp_ff;
	logic       sum_ff;
	logic [3:0] nxt_act;
	logic [3:0] nxt_trp;
	logic       nxt_sum;

	always_comb begin
		nxt_act = i_active;
		nxt_trp = i_tripped;
		nxt_sum = |i_tripped; // RULE8
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			act_ff <= 4'h0; // RULE7
			trp_ff <= 4'h0;
			sum_ff <= 1'b0;
		end else begin
			act_ff <= nxt_act;
			trp_ff <= nxt_trp;
			sum_ff <= nxt_sum;
		end
	end

	assign flags.active  = act_ff;
	assign flags.tripped = trp_ff;
	assign flags.summary = sum_ff;
endmodule : rasr_flag_hold

// File: core/rasr_regs.sv
// module: range select and alarm status registers on a wishbone slave
// Operation
// RULE1 - range select sits at byte address 0x14, lanes 0x14 to 0x17.
// RULE2 - range select bits 31-16, 15-8, 7 and 5-4 always read zero.
// RULE3 - bit 6 is read/write, resets to 0, and 1 disables the reference.
// RULE4 - bits 3-0 are the read/write range code, reset to 0000b.
// RULE5 - alarm status sits at byte address 0x20, lanes 0x20 to 0x23.
// RULE6 - active flags at 15,14,11,10, tripped at 7..4, summary at 0.
// RULE7 - alarm status is read-only, resets to zero, reserved bits zero.
// RULE8 - summary alarm is the OR of the four tripped flags.
// RULE9 - writes to read-only or reserved bits are ignored.
module rasr_regs (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic        i_wb_we,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic [3:0]  i_alarm_active,
	input  wire logic [3:0]  i_alarm_tripped,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	output logic      [3:0]  o_range_code,
	output logic             o_internal_ref_disable,
	output logic             o_range_code_valid
);
	// ****************************************************************
	// flag holder
	// ****************************************************************
	rasr_flag_if flag_bus ();

	rasr_flag_hold u_flags (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_active  (i_alarm_active),
		.i_tripped (i_alarm_tripped),
		.flags     (flag_bus.holder)
	);

	// ****************************************************************
	// bus slave state
	// ****************************************************************
	logic [3:0]  range_ff;
	logic        ref_dis_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic        valid_ff;
	logic [3:0]  nxt_range;
	logic        nxt_ref_dis;
	logic        nxt_ack;
	logic [31:0] nxt_rdat;
	logic        nxt_valid;
	logic        req;
	logic [7:0]  word_adr;
	logic [31:0] alarm_word;
	logic [31:0] range_word;

	always_comb begin
		req       = i_wb_cyc && i_wb_stb && !ack_ff;
		word_adr  = {i_wb_adr[7:2], 2'b00};
		range_word = 32'h0000_0000; // RULE2
		range_word[rasr_pkg::REF_DIS_BIT] = ref_dis_ff;
		range_word[rasr_pkg::RANGE_LSB +: rasr_pkg::RANGE_W] = range_ff;
		alarm_word = 32'h0000_0000; // RULE7
		alarm_word[rasr_pkg::ACT_SUP_LOW_BIT]  = flag_bus.active[3]; // RULE6
		alarm_word[rasr_pkg::ACT_SUP_HIGH_BIT] = flag_bus.active[2];
		alarm_word[rasr_pkg::ACT_IN_LOW_BIT]   = flag_bus.active[1];
		alarm_word[rasr_pkg::ACT_IN_HIGH_BIT]  = flag_bus.active[0];
		alarm_word[rasr_pkg::TRP_SUP_LOW_BIT]  = flag_bus.tripped[3];
		alarm_word[rasr_pkg::TRP_SUP_HIGH_BIT] = flag_bus.tripped[2];
		alarm_word[rasr_pkg::TRP_IN_LOW_BIT]   = flag_bus.tripped[1];
		alarm_word[rasr_pkg::TRP_IN_HIGH_BIT]  = flag_bus.tripped[0];
		alarm_word[rasr_pkg::SUMMARY_BIT]      = flag_bus.summary; // RULE8
		nxt_range   = range_ff;
		nxt_ref_dis = ref_dis_ff;
		nxt_ack     = req;
		nxt_rdat    = rdat_ff;
		if (req) begin
			case (word_adr)
				rasr_pkg::RANGE_SEL_ADDR: begin // RULE1
					nxt_rdat = range_word;
					if (i_wb_we && i_wb_sel[0]) begin // RULE9
						nxt_ref_dis = i_wb_dat[rasr_pkg::REF_DIS_BIT]; // RULE3
						nxt_range = i_wb_dat[rasr_pkg::RANGE_LSB +:
							rasr_pkg::RANGE_W]; // RULE4
					end
				end
				rasr_pkg::ALARM_STAT_ADDR: begin // RULE5
					nxt_rdat = alarm_word; // RULE9
				end
				default: begin
					nxt_rdat = rasr_pkg::UNMAPPED_DATA;
				end
			endcase
		end
		nxt_valid = (nxt_range <= rasr_pkg::RANGE_BIP_MAX) ||
			((nxt_range >= rasr_pkg::RANGE_UNI_MIN) &&
			 (nxt_range <= rasr_pkg::RANGE_UNI_MAX));
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			range_ff   <= rasr_pkg::RANGE_RST; // RULE4
			ref_dis_ff <= rasr_pkg::REF_DIS_RST; // RULE3
			ack_ff     <= 1'b0;
			rdat_ff    <= 32'h0000_0000;
			valid_ff   <= 1'b1;
		end else begin
			range_ff   <= nxt_range;
			ref_dis_ff <= nxt_ref_dis;
			ack_ff     <= nxt_ack;
			rdat_ff    <= nxt_rdat;
			valid_ff   <= nxt_valid;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign o_wb_dat               = rdat_ff;
	assign o_wb_ack               = ack_ff;
	assign o_range_code           = range_ff;
	assign o_internal_ref_disable = ref_dis_ff;
	assign o_range_code_valid     = valid_ff;
endmodule : rasr_regs

// File: test/rasr_regs_checker.sv
// checker: bus and field assertions bound onto the range/alarm bank
module rasr_regs_checker (
	input wire logic        i_clk_sys,
	input wire logic        i_reset_n,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0]  i_wb_sel,
	input wire logic        i_wb_we,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic [3:0]  i_alarm_active,
	input wire logic [3:0]  i_alarm_tripped,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_wb_ack,
	input wire logic [3:0]  o_range_code,
	input wire logic        o_internal_ref_disable,
	input wire logic        o_range_code_valid
);
	// ****
	// assertions
	// ****
	logic [31:0] alm;
	logic [4:0]  fld;
	logic        tk, wr, hr, ha;
	assign alm = {16'h0000, i_alarm_active[3:2], 2'h0, i_alarm_active[1:0],
		2'h0, i_alarm_tripped, 3'h0, |i_alarm_tripped};
	assign fld = {i_wb_dat[6], i_wb_dat[3:0]};
	assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign hr = i_wb_adr[7:2] == rasr_pkg::RANGE_SEL_ADDR[7:2];
	assign ha = i_wb_adr[7:2] == rasr_pkg::ALARM_STAT_ADDR[7:2];
	assign wr = tk && i_wb_we && i_wb_sel[0] && hr;
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);
	sequence s_ack;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	a_ack_pulse: assert property (tk |=> s_ack)
		else $error("ack not a single pulse");
	a_ack_cause: assert property (!tk |=> !o_wb_ack)
		else $error("ack without request");
	a_range_write: assert property (wr |=>
		{o_internal_ref_disable, o_range_code} == $past(fld))
		else $error("range write lost");
	a_range_hold: assert property (!wr |=> $stable(o_range_code) &&
		$stable(o_internal_ref_disable)) else $error("range changed");
	a_range_read: assert property (tk && !i_wb_we && hr |=> o_wb_dat ==
		{25'h000_0000, o_internal_ref_disable, 2'h0, o_range_code})
		else $error("range read wrong");
	a_alarm_read: assert property (tk && !i_wb_we && ha |=>
		o_wb_dat == $past(alm, 2)) else $error("alarm read wrong");
	a_unmapped_zero: assert property (tk && !i_wb_we && !hr && !ha |=>
		o_wb_dat == 32'h0000_0000) else $error("unmapped read not zero");
	a_code_valid: assert property (o_range_code_valid ==
		(o_range_code <= 4'h4 || o_range_code[3:2] == 2'h2))
		else $error("valid flag wrong");
endmodule : rasr_regs_checker
bind rasr_regs rasr_regs_checker i_rasr_regs_checker (.*);

// File: test/tb_top.sv
// testbench: random and corner register traffic for the range/alarm bank
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// stimulus and checks
	// ****
	logic        i_clk_sys = 1'b0, i_reset_n = 1'b0, i_wb_we = 1'b0;
	logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, o_wb_ack, ref_dis = 1'b0;
	logic        o_internal_ref_disable, o_range_code_valid;
	logic [7:0]  i_wb_adr = 8'h00;
	logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat, q, d, r;
	logic [31:0] seed = 32'h5243_84fe;
	logic [3:0]  i_wb_sel = 4'h0, i_alarm_active = 4'h0, s, rng = 4'h0;
	logic [3:0]  i_alarm_tripped = 4'h0, o_range_code;
	int          error_cnt = 0, checks_done = 0;
	always #2.5 i_clk_sys = ~i_clk_sys;
	rasr_regs i_rasr_regs (.*);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] alm_w(logic [3:0] a, logic [3:0] t);
		return {16'h0000, a[3:2], 2'h0, a[1:0], 2'h0, t, 3'h0, |t};
	endfunction : alm_w
	task automatic chk(input logic [31:0] seen, exp, input string nm);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		input logic [3:0] ws, output logic [31:0] rd);
		@(posedge i_clk_sys);
		{i_wb_cyc, i_wb_stb, i_wb_adr, i_wb_we, i_wb_dat} <= {2'h3, a, w, wd};
		i_wb_sel <= ws;
		do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
		rd = o_wb_dat;
		{i_wb_cyc, i_wb_stb} <= 2'h0;
	endtask : wb
	initial begin
		#20000;
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		wb(8'h14, 1'b0, 32'h0000_0000, 4'hf, q);
		chk(q, 32'h0000_0000, "range reset");
		wb(8'h20, 1'b0, 32'h0000_0000, 4'hf, q);
		chk(q, 32'h0000_0000, "alarm reset");
		for (int i = 0; i < 40; i++) begin
			r = rnd();
			d = rnd();
			s = (i < 12) ? 4'h1 : r[15:12];
			if (i < 12) d[3:0] = i[3:0];
			wb(8'h14 + i[1:0], 1'b1, d, s, q);
			if (s[0]) {ref_dis, rng} = {d[6], d[3:0]};
			wb(8'h17 - i[1:0], 1'b0, rnd(), 4'hf, q);
			chk(q, {25'h000_0000, ref_dis, 2'h0, rng}, "range");
			chk(o_range_code, rng, "code out");
			chk(o_internal_ref_disable, ref_dis, "ref out");
			chk(o_range_code_valid, (rng <= 4'h4) || (rng[3:2] == 2'h2),
				"valid out");
			{i_alarm_active, i_alarm_tripped} <= r[7:0];
			wb(8'h20 + i[1:0], 1'b1, rnd(), 4'hf, q);
			wb(8'h23 - i[1:0], 1'b0, 32'h0000_0000, 4'hf, q);
			chk(q, alm_w(r[7:4], r[3:0]), "alarm");
			wb({2'h3, r[21:16]}, r[22], rnd(), 4'hf, q);
			if (!r[22]) chk(q, 32'h0000_0000, "unmapped");
		end
		test_done();
	end
endmodule : tb_top
